// ===== verilog/serdes_reset_pkg.sv
// package: constants and types for the device reset controller
package serdes_reset_pkg;
   localparam int unsigned CLK_PERIOD_NS    = 8;
   // outputs settle in fewer than this many reference clocks after release
   localparam int unsigned SETTLE_LIMIT_CYC = 16;
   // internal settle sequence length, kept below the limit
   localparam int unsigned SETTLE_CYC       = SETTLE_LIMIT_CYC - 4;
   localparam int unsigned CNT_W            = 4;
   localparam logic [CNT_W-1:0] SETTLE_LAST =
      CNT_W'(SETTLE_CYC - 1);
   localparam int unsigned CFG_W            = 8;
   localparam logic [CFG_W-1:0] SELFTEST_CFG_RST = 8'h00;
   localparam logic [CFG_W-1:0] OE_CFG_RST       = 8'h00;
   localparam logic [CFG_W-1:0] RX_CFG_RST       = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST          = 4'h0;

   typedef enum logic [1:0] {
      ST_RESET,
      ST_SETTLE,
      ST_RUN
   } seq_state_t;

   typedef struct packed {
      logic [CFG_W-1:0] selftest;
      logic [CFG_W-1:0] output_enable;
      logic [CFG_W-1:0] receive;
   } cfg_latches_t;
endpackage : serdes_reset_pkg

// ===== verilog/serdes_device_reset_sync.sv
// device-wide reset control: sequencer, settle counter, configuration latches
// Operation
// - device reset low restores every state machine and counter
// - reset acts only when sampled low on a reference clock edge
// - release at first high sample; outputs settle within 16 cycles
// - reset clears self-test, output-enable and receive cfg latches
`timescale 1ns/1ps
`default_nettype none
module serdes_device_reset_sync
   import serdes_reset_pkg::*;
(
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   input  wire logic             device_reset_n_i,
   input  wire logic             selftest_cfg_latch_enable_i,
   input  wire logic             output_enable_cfg_latch_enable_i,
   input  wire logic             receive_cfg_latch_enable_i,
   input  wire logic [CFG_W-1:0] cfg_data_i,
   output logic                  core_reset_o,
   output logic                  outputs_valid_o,
   output cfg_latches_t          cfg_o
);

   ////////////////////////////////////////////////////////////////////////////
   seq_state_t       state;
   seq_state_t       next_state;
   logic [CNT_W-1:0] settle_cnt;
   logic [CNT_W-1:0] next_settle_cnt;
   cfg_latches_t     next_cfg;

   // clk_sys_i is the reference clock; pin level taken as synchronous
   wire dev_rst = ~device_reset_n_i | ~rst_n_i;
   wire settle_done = (settle_cnt == SETTLE_LAST);

   // sequencer state and settle counter rely on the host pulsing reset after power-up
   always_comb begin
      next_state      = state;
      next_settle_cnt = settle_cnt;
      unique case (state)
         ST_RESET: begin
            next_state      = ST_SETTLE;
            next_settle_cnt = CNT_RST;
         end
         ST_SETTLE: begin
            next_settle_cnt = settle_cnt + CNT_W'(1);
            if (settle_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            next_settle_cnt = CNT_RST;
         end
      endcase
   end

   always_comb begin
      next_cfg = cfg_o;
      if (selftest_cfg_latch_enable_i) begin
         next_cfg.selftest = cfg_data_i;
      end
      if (output_enable_cfg_latch_enable_i) begin
         next_cfg.output_enable = cfg_data_i;
      end
      if (receive_cfg_latch_enable_i) begin
         next_cfg.receive = cfg_data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_i) begin
      if (dev_rst) begin
         state      <= ST_RESET;
         settle_cnt <= CNT_RST;
      end else begin
         state      <= next_state;
         settle_cnt <= next_settle_cnt;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (dev_rst) begin
         cfg_o.selftest      <= SELFTEST_CFG_RST;
         cfg_o.output_enable <= OE_CFG_RST;
         cfg_o.receive       <= RX_CFG_RST;
      end else begin
         cfg_o <= next_cfg;
      end
   end

   // registered so downstream logic sees glitch-free levels
   always_ff @(posedge clk_sys_i) begin
      if (dev_rst) begin
         core_reset_o    <= 1'b1;
         outputs_valid_o <= 1'b0;
      end else begin
         core_reset_o    <= (state == ST_RESET);
         outputs_valid_o <= (next_state == ST_RUN);
      end
   end

endmodule : serdes_device_reset_sync
`default_nettype wire

// ===== sim/host_reset_model.sv
// host model: drives device reset, held from power-up
`timescale 1ns/1ps
`default_nettype none
module host_reset_model (
   input  wire logic clk_sys_i,
   input  wire logic req_i,
   output var  logic device_reset_n_o = 1'b0
);
   always @(posedge clk_sys_i) device_reset_n_o <= #1 !req_i;
endmodule : host_reset_model
`default_nettype wire

// ===== sim/serdes_reset_monitor.sv
// assertions on the reset controller ports
`timescale 1ns/1ps
`default_nettype none
module serdes_reset_monitor
   import serdes_reset_pkg::*;
(
   input wire logic         clk_sys_i,
   input wire logic         rst_n_i,
   input wire logic         device_reset_n_i,
   input wire logic         core_reset_o,
   input wire logic         outputs_valid_o,
   input wire cfg_latches_t cfg_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_release;
      !device_reset_n_i ##1 device_reset_n_i;
   endsequence
   a_reset_holds_core: assert property (!device_reset_n_i |=>
      core_reset_o && !outputs_valid_o) else $error("core not in reset");
   a_reset_clears_cfg: assert property (!device_reset_n_i |=>
      cfg_o == '0) else $error("latches not cleared");
   a_reset_edge_only: assert property ($rose(core_reset_o) |->
      $past(!device_reset_n_i)) else $error("reset without low sample");
   a_settle_in_time: assert property (s_release ##1
      device_reset_n_i[*8] ##1 device_reset_n_i[*7] |-> outputs_valid_o)
      else $error("outputs not valid in time");
endmodule : serdes_reset_monitor
bind serdes_device_reset_sync serdes_reset_monitor mon (.clk_sys_i,
   .rst_n_i, .device_reset_n_i, .core_reset_o, .outputs_valid_o, .cfg_o);
`default_nettype wire

// ===== sim/test_serdes_device_reset_sync.sv
// bench: random latch loads mixed with host reset pulses
`timescale 1ns/1ps
`default_nettype none
module test_serdes_device_reset_sync;
   import serdes_reset_pkg::*;
   logic clk_sys_i = 0, rst_n_i = 0, rq = 1, rq_prev = 1, dev_n;
   logic [2:0] en = 0;
   logic [CFG_W-1:0] d = 0;
   logic [31:0] seed = 32'hecf4_9956;
   cfg_latches_t cfg_o, ex = '0;
   logic core_o, valid_o;
   logic [25:0] q[$], nx;
   int fails = 0, tests_run = 0, cyc = 0, since = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   host_reset_model host (.clk_sys_i, .req_i(rq), .device_reset_n_o(dev_n));
   serdes_device_reset_sync dut (.clk_sys_i, .rst_n_i,
      .device_reset_n_i(dev_n), .selftest_cfg_latch_enable_i(en[2]),
      .output_enable_cfg_latch_enable_i(en[1]),
      .receive_cfg_latch_enable_i(en[0]), .cfg_data_i(d),
      .core_reset_o(core_o), .outputs_valid_o(valid_o), .cfg_o);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction : xs
   task automatic print_verdict;
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   task automatic chk(input string n, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   // enables driven in a reset cycle must be refused
   task automatic step(input logic r);
      @(posedge clk_sys_i);
      #1 seed = xs(seed);
      {en, d} = seed[10:0];
      rq = r;
      if (rq_prev) begin
         ex = '0;
         since = 0;
      end else begin
         ex = '{en[2] ? d : ex.selftest, en[1] ? d : ex.output_enable,
                en[0] ? d : ex.receive};
         if (since < 20) since++;
      end
      rq_prev = r;
      // since counts non-reset edges; the release edge itself is one
      q.push_back({since <= 1, since > SETTLE_CYC, ex});
   endtask : step
   always @(posedge clk_sys_i) if (q.size() > 0) begin
      #1 nx = q.pop_front();
      chk("cfg_o", 32'(cfg_o), 32'(nx[23:0]));
      chk("core_reset_o", 32'(core_o), 32'(nx[25]));
      chk("outputs_valid_o", 32'(valid_o), 32'(nx[24]));
   end
   always @(posedge clk_sys_i) if (++cyc == 600) begin
      fails++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge clk_sys_i);
      #1 rst_n_i = 1;
      for (int i = 0; i < 90; i++) step(i < 60 && seed[15:13] == 3'h0);
      repeat (3) @(posedge clk_sys_i);
      print_verdict();
   end
endmodule : test_serdes_device_reset_sync
`default_nettype wire
